// ==== hw/pmc_pkg.sv ====
// Package: codes, response codes and layout constants for the command decoder
package pmc_pkg;
	// Request main and sub codes
	localparam logic [7:0] PMC_MAIN_OPER = 8'h30;
	localparam logic [7:0] PMC_SUB_OPER = 8'h05;
	localparam logic [7:0] PMC_MAIN_ATTR = 8'h05;
	localparam logic [7:0] PMC_SUB_ATTR = 8'h03;
	localparam logic [7:0] PMC_MAIN_STAT = 8'h06;
	localparam logic [7:0] PMC_SUB_STAT = 8'h01;
	// Instruction codes
	localparam logic [7:0] PMC_INS_WRPERM = 8'h00;
	localparam logic [7:0] PMC_INS_FZERO = 8'h03;
	localparam logic [7:0] PMC_INS_SWRST = 8'h06;
	localparam logic [7:0] PMC_INS_AREA1 = 8'h07;
	localparam logic [7:0] PMC_INS_PROT = 8'h08;
	// Related information values
	localparam logic [7:0] PMC_REL_OFF = 8'h00;
	localparam logic [7:0] PMC_REL_ON = 8'h01;
	// Response codes
	localparam logic [15:0] PMC_RSP_OK = 16'h0000;
	localparam logic [15:0] PMC_RSP_LONG = 16'h1001;
	localparam logic [15:0] PMC_RSP_NVM = 16'h2203;
	localparam logic [15:0] PMC_RSP_OPERR = 16'h2203;
	localparam logic [15:0] PMC_RSP_BADCMD = 16'h0401;
	// Attribute data
	localparam logic [15:0] PMC_BUF_SIZE = 16'h0068;
	localparam int PMC_NAME_LEN = 10;
	localparam logic [7:0] PMC_BLANK = 8'h20;
	// Lockout value that forbids entering setting area 1
	localparam logic [1:0] PMC_LOCK_NOAREA1 = 2'h2;
	// Status byte bit positions and unknown marker
	localparam int PMC_ST_NOVAL = 0;
	localparam int PMC_ST_RANGE = 1;
	localparam int PMC_ST_ANOM = 2;
	localparam logic [7:0] PMC_ST_UNKNOWN = 8'hFF;
	// Operation status values
	localparam logic [7:0] PMC_OPS_RUN = 8'h00;
	localparam logic [7:0] PMC_OPS_SUSP = 8'h01;
	// Register port offsets
	localparam logic [3:0] PMC_A_CMD = 4'h0;
	localparam logic [3:0] PMC_A_ARG = 4'h1;
	localparam logic [3:0] PMC_A_GO = 4'h2;
	localparam logic [3:0] PMC_A_RSP = 4'h3;
	localparam logic [3:0] PMC_A_DATA = 4'h4;
	localparam logic [3:0] PMC_A_STATE = 4'h5;
	localparam logic [3:0] PMC_A_NAME = 4'h6;
	localparam logic [3:0] PMC_A_NAME_LAST = 4'h8;
	// Area states
	typedef enum logic [1:0] {PMC_AREA0, PMC_AREA1, PMC_PROTECT} pmc_area_type;
endpackage

// ==== hw/pmc_cond_if.sv ====
// Interface: condition summary between the decoder and its evaluator
`timescale 1ns/1ps
interface pmc_cond_if;
	logic [2:0] meas_flags;
	logic fz_block;
	logic [7:0] op_status;
	logic [7:0] rel_info;
	modport eval (
		input meas_flags,
		output fz_block,
		output op_status,
		output rel_info
	);
	modport user (
		output meas_flags,
		input fz_block,
		input op_status,
		input rel_info
	);
endinterface

// ==== hw/pmc_cond_eval.sv ====
// Module: measurement condition evaluator for zero forcing and status read
`timescale 1ns/1ps
module pmc_cond_eval
	import pmc_pkg::*;
(
	input wire logic hold_evt_i,
	input wire logic in_area1_i,
	pmc_cond_if.eval c
);
	// Status byte and forced-zero block
	always_comb begin
		c.rel_info = 8'h00;
		c.rel_info[PMC_ST_NOVAL] = c.meas_flags[0];
		c.rel_info[PMC_ST_RANGE] = c.meas_flags[1];
		c.rel_info[PMC_ST_ANOM] = c.meas_flags[2];
		if (in_area1_i) begin
			c.rel_info = PMC_ST_UNKNOWN;
		end
		c.op_status = (|c.meas_flags) ? PMC_OPS_SUSP : PMC_OPS_RUN;
		c.fz_block = (|c.meas_flags) | hold_evt_i;
	end
endmodule // pmc_cond_eval

// ==== hw/pmc_decoder.sv ====
// Module: operation, attribute and status command decoder of a panel meter
// ---------------------------------------------------------------------
// Functional notes
// - 30/05/00 sets or clears write permission
// - Permission off rejects writing instructions
// - Permission instruction accepted in every area state
// - Code 03 cancels or executes zero forcing
// - Zero forcing in area 1 errors
// - Zero forcing errors on bad measurement
// - Zero forcing errors under value hold
// - Code 06 restarts to power-on state
// - Software reset sends no response
// - Code 07 moves area 0 to 1
// - Move to area 1 ignored there
// - Lockout value 2 makes move error
// - Code 08 to protect; area 1 errors
// - Attribute read returns buffer size; 10-byte blank-padded name read at register port
// - Buffer size always 0068 hex
// - Attribute and status reads accepted in every area state
// - Read codes 0000, 1001, 2203
// - Status 00 normal, 01 suspended
// - Area 1 gives unknown related information
// ---------------------------------------------------------------------
`timescale 1ns/1ps
module pmc_decoder
	import pmc_pkg::*;
#(
	// Model name, arbitrary neutral value
	parameter logic [8*PMC_NAME_LEN-1:0] MODEL_NAME = "PMETER1   "
)
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [3:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic no_value_i,
	input wire logic range_over_i,
	input wire logic anomaly_i,
	input wire logic hold_evt_i,
	input wire logic nvm_fault_i,
	input wire logic [1:0] init_lockout_i,
	output logic wr_perm_o,
	output logic fz_active_o,
	output logic [1:0] area_o,
	output logic soft_rst_o,
	output logic rsp_valid_o,
	output logic [31:0] rsp_o
);
	// -----------------------------------------------------------------
	// Pin synchronisers
	// -----------------------------------------------------------------
	logic [3:0] s1_q;
	logic [3:0] s2_q;
	logic [3:0] s3_q;
	logic [3:0] cond_q;
	logic [3:0] raw;
	assign raw = {hold_evt_i, anomaly_i, range_over_i, no_value_i};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			// Three-stage sync; accept when last two agree
			// Agreement filters a level caught mid-change
			always_ff @(posedge clk_i) begin
				if (sys_rst_i) begin
					s1_q[gi] <= 1'b0;
					s2_q[gi] <= 1'b0;
					s3_q[gi] <= 1'b0;
					cond_q[gi] <= 1'b0;
				end else begin
					s1_q[gi] <= raw[gi];
					s2_q[gi] <= s1_q[gi];
					s3_q[gi] <= s2_q[gi];
					if (s2_q[gi] == s3_q[gi]) begin
						cond_q[gi] <= s3_q[gi];
					end
				end
			end
		end
	endgenerate

	// -----------------------------------------------------------------
	// Command registers
	// -----------------------------------------------------------------
	logic [15:0] cmd_q;
	logic [15:0] arg_q;
	logic [7:0] len_q;
	logic go_q;
	// Latch command, argument and length; GO starts decode
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cmd_q <= 16'h0000;
			arg_q <= 16'h0000;
			len_q <= 8'h00;
			go_q <= 1'b0;
		end else begin
			go_q <= wr_i && (addr_i == PMC_A_GO);
			if (wr_i && addr_i == PMC_A_CMD) begin
				cmd_q <= wdata_i[15:0];
			end
			if (wr_i && addr_i == PMC_A_ARG) begin
				arg_q <= wdata_i[15:0];
				len_q <= wdata_i[23:16];
			end
		end
	end

	// -----------------------------------------------------------------
	// Condition evaluator
	// -----------------------------------------------------------------
	// Evaluator sees synchronised pin levels and the area 1 state
	pmc_area_type area_q;
	pmc_cond_if cif ();
	assign cif.meas_flags = cond_q[2:0];
	pmc_cond_eval u_eval (
		.hold_evt_i(cond_q[3]),
		.in_area1_i(area_q == PMC_AREA1),
		.c(cif)
	);

	// -----------------------------------------------------------------
	// Decode
	// -----------------------------------------------------------------
	logic [7:0] main_request_code;
	logic [7:0] sub_request_code;
	logic [7:0] ins;
	logic [7:0] rel;
	logic is_oper;
	logic is_attr;
	logic is_stat;
	logic too_long;
	assign main_request_code = cmd_q[15:8];
	assign sub_request_code = cmd_q[7:0];
	assign ins = arg_q[15:8];
	assign rel = arg_q[7:0];
	assign is_oper = main_request_code == PMC_MAIN_OPER
		&& sub_request_code == PMC_SUB_OPER;
	assign is_attr = main_request_code == PMC_MAIN_ATTR
		&& sub_request_code == PMC_SUB_ATTR;
	assign is_stat = main_request_code == PMC_MAIN_STAT
		&& sub_request_code == PMC_SUB_STAT;
	// Reads carry no argument; any length is over
	assign too_long = len_q != 8'h00;

	logic wr_perm_d;
	logic fz_d;
	pmc_area_type area_d;
	logic srst_d;
	logic rsp_d;
	logic [15:0] code_d;
	logic [15:0] data_d;
	// Instruction evaluation
	always_comb begin
		wr_perm_d = wr_perm_o;
		fz_d = fz_active_o;
		area_d = area_q;
		srst_d = 1'b0;
		rsp_d = 1'b0;
		code_d = PMC_RSP_OK;
		data_d = 16'h0000;
		if (go_q) begin
			rsp_d = 1'b1;
			if (is_attr || is_stat) begin
				if (too_long) begin
					code_d = PMC_RSP_LONG;
				end else if (nvm_fault_i) begin
					code_d = PMC_RSP_NVM;
				end else if (is_attr) begin
					data_d = PMC_BUF_SIZE;
				end else begin
					data_d = {cif.op_status, cif.rel_info};
				end
			end else if (!is_oper) begin
				code_d = PMC_RSP_BADCMD;
			end else if (ins == PMC_INS_WRPERM) begin
				if (rel == PMC_REL_OFF || rel == PMC_REL_ON) begin
					wr_perm_d = rel[0];
				end else begin
					code_d = PMC_RSP_OPERR;
				end
			end else if (!wr_perm_o) begin
				code_d = PMC_RSP_OPERR;
			end else begin
				case (ins)
					PMC_INS_FZERO: begin
						if (area_q == PMC_AREA1 || cif.fz_block
							|| rel > PMC_REL_ON) begin
							code_d = PMC_RSP_OPERR;
						end else begin
							fz_d = rel[0];
						end
					end
					PMC_INS_SWRST: begin
						if (rel == PMC_REL_OFF) begin
							srst_d = 1'b1;
							rsp_d = 1'b0;
						end else begin
							code_d = PMC_RSP_OPERR;
						end
					end
					PMC_INS_AREA1: begin
						if (area_q == PMC_AREA1) begin
							rsp_d = 1'b0;
						end else if (init_lockout_i == PMC_LOCK_NOAREA1
							|| rel != PMC_REL_OFF) begin
							code_d = PMC_RSP_OPERR;
						end else begin
							area_d = PMC_AREA1;
						end
					end
					PMC_INS_PROT: begin
						if (area_q == PMC_AREA1 || rel != PMC_REL_OFF) begin
							code_d = PMC_RSP_OPERR;
						end else begin
							area_d = PMC_PROTECT;
						end
					end
					default: begin
						code_d = PMC_RSP_OPERR;
					end
				endcase
			end
		end
	end

	// -----------------------------------------------------------------
	// State and response registers
	// -----------------------------------------------------------------
	// Device state; software reset returns power-on values
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || soft_rst_o) begin
			wr_perm_o <= 1'b0;
			fz_active_o <= 1'b0;
			area_q <= PMC_AREA0;
		end else begin
			wr_perm_o <= wr_perm_d;
			fz_active_o <= fz_d;
			area_q <= area_d;
		end
	end

	// Software reset pulse
	// One cycle wide, so state clears at the following edge
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			soft_rst_o <= 1'b0;
		end else begin
			soft_rst_o <= srst_d;
		end
	end

	// Codes of the request last answered, kept for the echo
	logic [15:0] echo_q;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rsp_valid_o <= 1'b0;
			rsp_o <= 32'h0000_0000;
			echo_q <= 16'h0000;
		end else begin
			rsp_valid_o <= rsp_d;
			if (rsp_d) begin
				rsp_o <= {code_d, data_d};
				echo_q <= cmd_q;
			end
		end
	end

	// Area output; both resets return it to area 0
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || soft_rst_o) begin
			area_o <= 2'h0;
		end else begin
			area_o <= area_d;
		end
	end

	// -----------------------------------------------------------------
	// Register read port
	// -----------------------------------------------------------------
	logic [3:0] nidx;
	logic [4:0] nbase;
	assign nidx = addr_i - PMC_A_NAME;
	assign nbase = 5'(nidx) << 2;
	// Read data valid the cycle after the strobe
	// Reads have no side effects; the word holds until the next read
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rdata_o <= 32'h0000_0000;
		end else if (rd_i) begin
			case (addr_i)
				PMC_A_CMD: rdata_o <= {16'h0000, cmd_q};
				PMC_A_ARG: rdata_o <= {8'h00, len_q, arg_q};
				PMC_A_RSP: rdata_o <= {echo_q, rsp_o[31:16]};
				PMC_A_DATA: rdata_o <= {16'h0000, rsp_o[15:0]};
				PMC_A_STATE: rdata_o <= {27'h0, cond_q[3],
					fz_active_o, wr_perm_o, 2'(area_q)};
				PMC_A_NAME, PMC_A_NAME + 4'h1, PMC_A_NAME_LAST: begin
					rdata_o <= name_word(nbase);
				end
				default: rdata_o <= 32'h0000_0000;
			endcase
		end
	end

	// -----------------------------------------------------------------
	// Model name lookup
	// -----------------------------------------------------------------
	// Four name bytes, first byte high; blanks past the end
	function automatic logic [31:0] name_word(input logic [4:0] b);
		logic [31:0] w;
		w = 32'h0000_0000;
		for (int k = 0; k < 4; k++) begin
			if (int'(b) + k < PMC_NAME_LEN) begin
				w[31-8*k -: 8] =
					MODEL_NAME[8*(PMC_NAME_LEN-1-(int'(b)+k)) +: 8];
			end else begin
				w[31-8*k -: 8] = PMC_BLANK;
			end
		end
		return w;
	endfunction
endmodule // pmc_decoder

// ==== verification/pmc_decoder_asserts.sv ====
// Checker: port-level assertions for the command decoder
`timescale 1ns/1ps
module pmc_decoder_asserts
	import pmc_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [3:0] addr_i,
	input wire logic wr_i,
	input wire logic [1:0] init_lockout_i,
	input wire logic wr_perm_o,
	input wire logic fz_active_o,
	input wire logic [1:0] area_o,
	input wire logic soft_rst_o,
	input wire logic rsp_valid_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// -----------------------------------------------------------------
	// Properties
	// -----------------------------------------------------------------
	property p_perm_rsp;
		$rose(wr_perm_o) |-> rsp_valid_o;
	endproperty
	property p_fz_gate;
		$rose(fz_active_o) |-> $past(wr_perm_o) && $past(area_o) != 2'h1;
	endproperty
	property p_move_gate;
		$changed(area_o) && area_o != 2'h0 |->
			$past(wr_perm_o) && $past(area_o) == 2'h0;
	endproperty
	property p_lock;
		$changed(area_o) && area_o == 2'h1 |->
			$past(init_lockout_i) != PMC_LOCK_NOAREA1;
	endproperty
	property p_go_rsp;
		wr_i && addr_i == PMC_A_GO && area_o != 2'h1 |->
			##2 (rsp_valid_o || soft_rst_o);
	endproperty
	property p_srst_quiet;
		soft_rst_o |-> !rsp_valid_o;
	endproperty
	property p_srst_clear;
		soft_rst_o |=> !wr_perm_o && !fz_active_o && area_o == 2'h0;
	endproperty
	property p_rsp_pulse;
		rsp_valid_o |=> !rsp_valid_o;
	endproperty
	property p_area_hold;
		area_o == 2'h1 && !soft_rst_o |=> area_o == 2'h1;
	endproperty
	a_perm_rsp: assert property (p_perm_rsp)
		else $error("permission changed without answer");
	a_fz_gate: assert property (p_fz_gate)
		else $error("zero forcing started while refused");
	a_move_gate: assert property (p_move_gate)
		else $error("level move from wrong area or without permission");
	a_lock: assert property (p_lock)
		else $error("area 1 entered under lockout");
	a_go_rsp: assert property (p_go_rsp)
		else $error("request not answered in two cycles");
	a_srst_quiet: assert property (p_srst_quiet)
		else $error("answer sent with software reset");
	a_srst_clear: assert property (p_srst_clear)
		else $error("software reset left state behind");
	a_rsp_pulse: assert property (p_rsp_pulse)
		else $error("answer strobe longer than one cycle");
	a_area_hold: assert property (p_area_hold)
		else $error("area 1 left without reset");
	// Main scenario covers
	c_rsp: cover property (rsp_valid_o);
	c_srst: cover property (soft_rst_o);
	c_prot: cover property (area_o == 2'h2);
endmodule // pmc_decoder_asserts

bind pmc_decoder pmc_decoder_asserts u_chk (.clk_i, .sys_rst_i, .addr_i,
	.wr_i, .init_lockout_i, .wr_perm_o, .fz_active_o, .area_o, .soft_rst_o,
	.rsp_valid_o);

// ==== verification/pmc_host_model.sv ====
// Host model: register-bus master that sequences decoder requests
`timescale 1ns/1ps
module pmc_host_model
	import pmc_pkg::*;
(
	input wire logic clk_i,
	output logic [3:0] addr_o,
	output logic [31:0] wdata_o,
	output logic wr_o,
	output logic rd_o,
	input wire logic [31:0] rdata_i
);
	// Idle bus at time zero
	initial begin
		addr_o = 4'h0;
		wdata_o = 32'h0;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// One-cycle write, data inverted once released
	task automatic put(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		wdata_o <= ~d;
	endtask
	// One-cycle read, data taken in the cycle after
	task automatic get(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		#1;
		d = rdata_i;
	endtask
	task automatic send(input logic [15:0] c, input logic [23:0] a);
		put(PMC_A_CMD, {16'h0, c});
		put(PMC_A_ARG, {8'h0, a});
		put(PMC_A_GO, 32'h0);
	endtask
	task automatic permit();
		send({PMC_MAIN_OPER, PMC_SUB_OPER}, {8'h0, PMC_INS_WRPERM, PMC_REL_ON});
		repeat (6) @(posedge clk_i);
	endtask
endmodule // pmc_host_model

// ==== verification/test_panel_meter_operation_commands.sv ====
// Testbench: directed scenarios for the command decoder
`timescale 1ns/1ps
module test_panel_meter_operation_commands
	import pmc_pkg::*;
();
	localparam logic [15:0] OPC = {PMC_MAIN_OPER, PMC_SUB_OPER};
	localparam logic [15:0] ATC = {PMC_MAIN_ATTR, PMC_SUB_ATTR};
	localparam logic [15:0] STC = {PMC_MAIN_STAT, PMC_SUB_STAT};
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [3:0] addr, cond;
	logic [31:0] wdata, rdata, rsp_o, rsp, d;
	logic wr, rd, wr_perm_o, fz_active_o, soft_rst_o, rsp_valid_o, nvm;
	logic [1:0] area_o, lock;
	logic seen, srst;
	int errors = 0;
	int samples_checked = 0;
	// 25 MHz clock
	always #20 clk_i = ~clk_i;
	pmc_host_model host (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata),
		.wr_o(wr), .rd_o(rd), .rdata_i(rdata));
	pmc_decoder #(.MODEL_NAME("ABCDEFG   ")) dut (.clk_i(clk_i),
		.sys_rst_i(sys_rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
		.rd_i(rd), .rdata_o(rdata), .no_value_i(cond[0]),
		.range_over_i(cond[1]), .anomaly_i(cond[2]), .hold_evt_i(cond[3]),
		.nvm_fault_i(nvm), .init_lockout_i(lock), .wr_perm_o(wr_perm_o),
		.fz_active_o(fz_active_o), .area_o(area_o), .soft_rst_o(soft_rst_o),
		.rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o));
	// -----------------------------------------------------------------
	// Shared tasks
	// -----------------------------------------------------------------
	task automatic summarize();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chkc(input string n, input logic [15:0] e);
		chk(n, {16'h1, e}, {15'h0, seen, rsp[31:16]});
	endtask
	task automatic op(input logic [15:0] c, input logic [23:0] a);
		host.send(c, a);
		seen = 1'b0;
		srst = 1'b0;
		repeat (6) begin
			@(negedge clk_i);
			if (rsp_valid_o === 1'b1) begin
				seen = 1'b1;
				rsp = rsp_o;
			end
			if (soft_rst_o === 1'b1) srst = 1'b1;
		end
	endtask
	task automatic ins(input logic [7:0] i, input logic [7:0] r);
		op(OPC, {8'h0, i, r});
	endtask
	task automatic setc(input logic [3:0] v);
		@(posedge clk_i);
		cond <= v;
		repeat (8) @(posedge clk_i);
	endtask
	// -----------------------------------------------------------------
	// Scenarios
	// -----------------------------------------------------------------
	task automatic t_perm();
		ins(PMC_INS_WRPERM, PMC_REL_ON);
		chk("perm rsp", 32'h00000000, rsp);
		host.get(PMC_A_RSP, d);
		chk("echo", {OPC, PMC_RSP_OK}, d);
		chk("perm on", 32'h1, {31'h0, wr_perm_o});
		ins(PMC_INS_WRPERM, 8'h02);
		chkc("perm bad", PMC_RSP_OPERR);
		ins(PMC_INS_WRPERM, PMC_REL_OFF);
		chk("perm off", 32'h0, {31'h0, wr_perm_o});
		ins(PMC_INS_FZERO, PMC_REL_ON);
		chkc("fz locked", PMC_RSP_OPERR);
	endtask
	task automatic t_fz();
		host.permit();
		for (int i = 0; i < 4; i++) begin
			setc(4'h1 << i);
			ins(PMC_INS_FZERO, PMC_REL_ON);
			chkc("fz blocked", PMC_RSP_OPERR);
		end
		setc(4'h0);
		ins(PMC_INS_FZERO, PMC_REL_ON);
		chkc("fz run", PMC_RSP_OK);
		chk("fz on", 32'h1, {31'h0, fz_active_o});
		ins(PMC_INS_FZERO, PMC_REL_OFF);
		chk("fz off", 32'h0, {31'h0, fz_active_o});
	endtask
	task automatic t_reads();
		setc(4'h5);
		op(STC, 24'h0);
		chk("status", {PMC_RSP_OK, PMC_OPS_SUSP, 8'h05}, rsp);
		setc(4'h0);
		op(STC, 24'h0);
		chk("status ok", {PMC_RSP_OK, PMC_OPS_RUN, 8'h00}, rsp);
		op(ATC, 24'h0);
		chk("attr", {PMC_RSP_OK, 16'h0068}, rsp);
		op(ATC, 24'h010000);
		chkc("attr long", PMC_RSP_LONG);
		@(posedge clk_i);
		nvm <= 1'b1;
		op(STC, 24'h0);
		chkc("nvm", PMC_RSP_NVM);
		@(posedge clk_i);
		nvm <= 1'b0;
		op(16'h7F7F, 24'h0);
		chkc("bad cmd", PMC_RSP_BADCMD);
		host.get(PMC_A_NAME, d);
		chk("name head", 32'h41424344, d);
		host.get(PMC_A_NAME + 4'h1, d);
		chk("name mid", 32'h45464720, d);
		host.get(PMC_A_NAME_LAST, d);
		chk("name tail", 32'h20202020, d);
	endtask
	task automatic t_area();
		@(posedge clk_i);
		lock <= PMC_LOCK_NOAREA1;
		ins(PMC_INS_AREA1, PMC_REL_OFF);
		chkc("lockout", PMC_RSP_OPERR);
		@(posedge clk_i);
		lock <= 2'h0;
		ins(PMC_INS_AREA1, PMC_REL_OFF);
		chk("area1", 32'h1, {30'h0, area_o});
		ins(PMC_INS_AREA1, PMC_REL_OFF);
		chk("ignored", 32'h0, {31'h0, seen});
		ins(PMC_INS_FZERO, PMC_REL_ON);
		chkc("fz area1", PMC_RSP_OPERR);
		ins(PMC_INS_PROT, PMC_REL_OFF);
		chkc("prot area1", PMC_RSP_OPERR);
		ins(PMC_INS_WRPERM, PMC_REL_ON);
		chkc("perm area1", PMC_RSP_OK);
		op(STC, 24'h0);
		chk("rel area1", {24'h0, PMC_ST_UNKNOWN}, {24'h0, rsp[7:0]});
		op(ATC, 24'h0);
		chk("attr area1", {PMC_RSP_OK, 16'h0068}, rsp);
		ins(PMC_INS_SWRST, PMC_REL_OFF);
		chk("no reply", 32'h1, {31'h0, srst & ~seen});
		chk("reset state", 32'h0, {28'h0, area_o, wr_perm_o, fz_active_o});
		host.permit();
		ins(PMC_INS_PROT, PMC_REL_OFF);
		chk("protect", 32'h2, {30'h0, area_o});
	endtask
	task automatic t_rst();
		@(posedge clk_i);
		sys_rst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(negedge clk_i);
		chk("sys reset", 32'h0, {28'h0, area_o, wr_perm_o, fz_active_o});
		ins(PMC_INS_FZERO, PMC_REL_ON);
		chkc("fz after reset", PMC_RSP_OPERR);
	endtask
	// Main sequence
	initial begin
		nvm = 1'b0;
		lock = 2'h0;
		cond = 4'h0;
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		t_perm();
		t_fz();
		t_reads();
		t_area();
		t_rst();
		summarize();
	end
	// Run time limit
	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		$display("[FAIL] run time expected end seen limit");
		summarize();
	end
endmodule // test_panel_meter_operation_commands
